// *** shared/fbr_pkg.sv ***
// shared types, constants and helpers of the flash burst read block
package fbr_pkg;

  // configuration word layout, msb first
  typedef struct packed {
    logic       read_mode_select;
    logic       rsvd_hi;
    logic [3:0] initial_latency_field;
    logic       output_hold_config;
    logic       end_flag_timing_select;
    logic       burst_seq;
    logic       clock_edge_select;
    logic [2:0] rsvd_lo;
    logic [2:0] burst_length_field;
  } fbr_cfg_t;

  // host pins sampled on the burst clock
  typedef struct packed {
    logic chip_sel_n;
    logic address_valid_strobe_n;
    logic out_gate_n;
  } fbr_link_t;

  localparam logic [15:0] CFG_RST     = 16'h9CC4;
  localparam logic [4:0]  LAT_BASE    = 5'h02;
  localparam logic [4:0]  LAT_LAST    = 5'h01;
  localparam logic [2:0]  BL_2DW      = 3'h1;
  localparam logic [2:0]  BL_4DW      = 3'h2;
  localparam logic [2:0]  BL_8DW      = 3'h3;
  localparam logic [2:0]  MASK_2DW    = 3'h1;
  localparam logic [2:0]  MASK_4DW    = 3'h3;
  localparam logic [2:0]  MASK_8DW    = 3'h7;
  localparam int          WRAP_W      = 3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LAT  = 2'b01,
    ST_XFER = 2'b11,
    ST_HOLD = 2'b10
  } fbr_state_t;

  // burst reads only with sync mode and a defined length code
  function automatic logic fbr_burst_en(input fbr_cfg_t c);
    return !c.read_mode_select &&
           (c.burst_length_field == BL_2DW ||
            c.burst_length_field == BL_4DW ||
            c.burst_length_field == BL_8DW);
  endfunction

  // word index mask of the wrap group
  function automatic logic [2:0] fbr_len_mask(input logic [2:0] bl);
    case (bl)
      BL_2DW:  return MASK_2DW;
      BL_4DW:  return MASK_4DW;
      default: return MASK_8DW;
    endcase
  endfunction

endpackage

// *** rtl/fbr_burst_read.sv ***
// burst read engine of a parallel flash: config holder and link side
`timescale 1ns/1ps
// Overview of operation
// (RL1) reset leaves the device in asynchronous reads
// (RL2) burst enabled means every array read bursts
// (RL3) burst starts at first edge with strobe low
// (RL4) latency field adds wait states before data
// (RL5) latency counted from the address capture edge
// (RL6) latency equals field value plus two cycles
// (RL7) latency never touches asynchronous read timing
// (RL8) bursts of 2, 4, 8 words wrap in group
// (RL9) end flag low on final transfer before wrap
// (RL10) continued clocking wraps back to start word
// (RL11) end flag floats while output gating high
// (RL12) timing bit picks last or second-to-last transfer
// (RL13) rising edges only, edge select held one
// (RL14) each data word stands one clock
// (RL15) hardware reset ends burst, restores defaults
// (RL16) chip select high exits burst, floats bus
// (RL17) host restarts with select and strobe low
// (RL18) new strobe discards address and restarts burst
// (RL19) output gating floats bus, burst keeps running
// (RL20) config and protection reads hold while gated
// (RL21) security region uses same timing, edge invalid
// (RL22) read mode zero bursts, one asynchronous
// (RL23) length codes one to three, others disable
// (RL24) config write during program or erase ignored
// (RL25) host counts latency then samples each edge
module fbr_burst_read #(
  parameter int AW = 20,
  parameter int DW = 32
) (
  input  wire logic              clock_i,
  input  wire logic              resetn_i,
  input  wire logic              cfg_wr_i,
  input  wire fbr_pkg::fbr_cfg_t cfg_wdata_i,
  input  wire logic              prog_busy_i,
  output logic                   cfg_pending_o,
  output fbr_pkg::fbr_cfg_t      cfg_o,
  output logic                   burst_mode_o,
  input  wire logic              burst_clk_i,
  input  wire fbr_pkg::fbr_link_t link_i,
  input  wire logic [AW-1:0]     addr_i,
  input  wire logic              special_read_i,
  input  wire logic [DW-1:0]     special_data_i,
  output logic [AW-1:0]          arr_addr_o,
  input  wire logic [DW-1:0]     arr_data_i,
  output logic [DW-1:0]          dq_o,
  output logic                   dq_oe_o,
  output logic                   end_of_burst_flag_n_o,
  output logic                   end_of_burst_flag_oe_o
);
  import fbr_pkg::*;

  // ---------------- system clock side ----------------
  fbr_cfg_t cfg_r;
  logic     req_r;
  logic     ack_s1_r;
  logic     ack_s2_r;
  logic     ack_r;
  logic     pend;
  logic     wr_ok;

  assign pend  = req_r != ack_s2_r;
  assign wr_ok = cfg_wr_i && !prog_busy_i && !pend;

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cfg_r <= fbr_cfg_t'(CFG_RST); // [RL1] [RL15] [RL22]
    end else if (wr_ok) begin // [RL24]
      cfg_r                   <= cfg_wdata_i;
      cfg_r.clock_edge_select <= 1'b1; // [RL13]
      cfg_r.output_hold_config <= 1'b0;
    end
  end

  // toggle handshake carries the word to the link side
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_r <= 1'b0;
    end else if (wr_ok) begin
      req_r <= ~req_r;
    end
  end

  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
    end else begin
      ack_s1_r <= ack_r;
      ack_s2_r <= ack_s1_r;
    end
  end

  assign cfg_pending_o = pend;
  assign cfg_o         = cfg_r;
  assign burst_mode_o  = fbr_burst_en(cfg_r); // [RL2] [RL23]

  // ---------------- burst clock side ----------------
  logic          lrst_s1_r;
  logic          link_rstn_r;
  logic          req_s1_r;
  logic          req_s2_r;
  fbr_cfg_t      cfg_lk_r;
  fbr_state_t    state_r;
  logic [4:0]    cnt_r;
  logic [4:0]    lat_r;
  logic [4:0]    since_r;
  logic [AW-1:0] base_r;
  logic [2:0]    beat_r;
  logic [2:0]    mask_r;
  logic          wc_r;
  logic [DW-1:0] dq_r;
  logic          eob_n_r;
  logic          start;
  logic          quit;
  logic          ld;
  logic [2:0]    last_idx;
  logic [2:0]    wrap_lo;
  logic [4:0]    lat_cfg;

  // reset asserts at once, releases on the burst clock
  always_ff @(posedge burst_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lrst_s1_r   <= 1'b0;
      link_rstn_r <= 1'b0;
    end else begin
      lrst_s1_r   <= 1'b1;
      link_rstn_r <= lrst_s1_r;
    end
  end

  // cfg_r is held still while the toggle is in flight
  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      req_s1_r <= 1'b0;
      req_s2_r <= 1'b0;
      ack_r    <= 1'b0;
      cfg_lk_r <= fbr_cfg_t'(CFG_RST); // [RL15]
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      if (req_s2_r != ack_r) begin
        cfg_lk_r <= cfg_r;
        ack_r    <= req_s2_r;
      end
    end
  end

  assign lat_cfg = {1'b0, cfg_lk_r.initial_latency_field} + LAT_BASE; // [RL6]
  assign quit    = link_i.chip_sel_n; // [RL16]
  // only bursting mode starts here; async reads bypass this engine
  assign start   = !link_i.chip_sel_n && !link_i.address_valid_strobe_n &&
                   fbr_burst_en(cfg_lk_r); // [RL3] [RL2] [RL7] [RL18]
  assign ld      = !quit && !start &&
                   ((state_r == ST_LAT && cnt_r == LAT_LAST) ||
                    state_r == ST_XFER); // [RL14]
  assign last_idx = wc_r ? mask_r - 3'h1 : mask_r; // [RL12]
  assign wrap_lo  = (base_r[2:0] + beat_r) & mask_r; // [RL8]
  assign arr_addr_o = {base_r[AW-1:WRAP_W], (base_r[2:0] & ~mask_r) | wrap_lo}; // [RL21]

  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      state_r <= ST_IDLE;
      cnt_r   <= 5'h00;
    end else if (quit) begin
      state_r <= ST_IDLE; // [RL16]
    end else if (start) begin
      state_r <= special_read_i ? ST_HOLD : ST_LAT; // [RL20]
      cnt_r   <= lat_cfg; // [RL4] [RL5]
    end else begin
      case (state_r)
        ST_LAT: begin
          if (cnt_r == LAT_LAST) begin
            state_r <= ST_XFER;
          end else begin
            cnt_r <= cnt_r - 5'h01;
          end
        end
        ST_XFER: state_r <= ST_XFER;
        ST_HOLD: state_r <= ST_HOLD;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // address, group and flag timing are frozen per burst
  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      base_r <= '0;
      mask_r <= MASK_8DW;
      wc_r   <= 1'b0;
      lat_r  <= 5'h00;
    end else if (start) begin
      base_r <= addr_i; // [RL3] [RL18]
      mask_r <= fbr_len_mask(cfg_lk_r.burst_length_field); // [RL8]
      wc_r   <= cfg_lk_r.end_flag_timing_select; // [RL12]
      lat_r  <= lat_cfg;
    end
  end

  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      beat_r <= 3'h0;
    end else if (start) begin
      beat_r <= 3'h0;
    end else if (ld) begin
      beat_r <= (beat_r + 3'h1) & mask_r; // [RL10]
    end
  end

  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      dq_r <= '0;
    end else if (start && special_read_i) begin
      dq_r <= special_data_i; // [RL20]
    end else if (ld) begin
      dq_r <= arr_data_i; // [RL14]
    end
  end

  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      eob_n_r <= 1'b1;
    end else if (ld) begin
      eob_n_r <= beat_r != last_idx; // [RL9] [RL12]
    end else begin
      eob_n_r <= 1'b1;
    end
  end

  // cycles since address capture, read by checks only
  always_ff @(posedge burst_clk_i or negedge link_rstn_r) begin
    if (!link_rstn_r) begin
      since_r <= 5'h00;
    end else if (start) begin
      since_r <= 5'h01;
    end else if (since_r != 5'h1F) begin
      since_r <= since_r + 5'h01;
    end
  end

  // gating acts at once; the sequence itself runs on
  assign dq_oe_o = link_rstn_r && !link_i.chip_sel_n && !link_i.out_gate_n &&
                   (state_r == ST_XFER || state_r == ST_HOLD); // [RL19] [RL15]
  assign dq_o    = dq_r;
  assign end_of_burst_flag_oe_o = link_rstn_r && !link_i.chip_sel_n &&
                   !link_i.out_gate_n &&
                   (state_r == ST_LAT || state_r == ST_XFER); // [RL11]
  assign end_of_burst_flag_n_o  = eob_n_r;

  // ---------------- checks ----------------
  a_reset_default: assert property (@(posedge clock_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> cfg_r == fbr_cfg_t'(CFG_RST))
    else $error("config not at default after reset"); // [RL1]

  a_busy_write_ignored: assert property (@(posedge clock_i) disable iff (!resetn_i)
    cfg_wr_i && prog_busy_i |=> $stable(cfg_r))
    else $error("config written while busy"); // [RL24]

  a_edge_select_one: assert property (@(posedge clock_i) disable iff (!resetn_i)
    cfg_wr_i |=> cfg_r.clock_edge_select)
    else $error("edge select left clear"); // [RL13]

  a_first_data_lat: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    ld && state_r == ST_LAT |-> since_r == lat_r)
    else $error("first word off latency count"); // [RL6]

  sequence s_capture;
    start && !special_read_i;
  endsequence

  sequence s_wait;
    state_r == ST_LAT [*2];
  endsequence

  a_start_waits: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    s_capture ##1 !start && !quit |-> s_wait)
    else $error("burst skipped wait states"); // [RL4]

  a_burst_wrap: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    ld && beat_r == mask_r |=> beat_r == 3'h0)
    else $error("burst did not wrap"); // [RL10]

  a_flag_one_clk: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    ld && beat_r == last_idx ##1 ld |=> eob_n_r)
    else $error("end flag longer than one clock"); // [RL12]

  a_select_exit: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    link_i.chip_sel_n |-> !dq_oe_o ##1 state_r == ST_IDLE)
    else $error("burst kept after deselect"); // [RL16]

  a_gate_keeps_run: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    ld && link_i.out_gate_n |-> !dq_oe_o ##1 state_r == ST_XFER)
    else $error("gating disturbed burst"); // [RL19]

  a_gate_flag_float: assert property (@(posedge burst_clk_i)
    disable iff (!link_rstn_r)
    link_i.out_gate_n |-> !end_of_burst_flag_oe_o)
    else $error("end flag driven while gated"); // [RL11]

  // ---------------- reset and config checks ----------------
  // pending must read clear while reset holds the toggle pair equal
  a_reset_no_pend: assert property (@(posedge clock_i) // [RL15]
    !resetn_i |-> !cfg_pending_o)
    else $error("write pending during reset");

  a_write_lands: assert property (@(posedge clock_i) // [RL4]
    disable iff (!resetn_i)
    wr_ok |=> cfg_r.initial_latency_field == $past(cfg_wdata_i.initial_latency_field))
    else $error("config write lost");

  a_hold_bit_clear: assert property (@(posedge clock_i) // [RL14]
    disable iff (!resetn_i)
    cfg_wr_i |=> !cfg_r.output_hold_config)
    else $error("output hold bit set");

  // ---------------- link side checks ----------------
  // link reset floats both drivers before the first burst clock edge
  a_link_reset_float: assert property (@(posedge burst_clk_i) // [RL15]
    !link_rstn_r |-> !dq_oe_o && !end_of_burst_flag_oe_o)
    else $error("bus driven in link reset");

  a_quit_float: assert property (@(posedge burst_clk_i) // [RL16]
    disable iff (!link_rstn_r)
    link_i.chip_sel_n |-> !dq_oe_o && !end_of_burst_flag_oe_o)
    else $error("bus driven while deselected");

  a_addr_capture: assert property (@(posedge burst_clk_i) // [RL3]
    disable iff (!link_rstn_r)
    start |=> base_r == $past(addr_i))
    else $error("start address not captured");

  a_latency_load: assert property (@(posedge burst_clk_i) // [RL6]
    disable iff (!link_rstn_r)
    start |=> cnt_r == $past(lat_cfg))
    else $error("latency count not loaded");

  a_word_advance: assert property (@(posedge burst_clk_i) // [RL14]
    disable iff (!link_rstn_r)
    ld ##1 ld |-> beat_r == (($past(beat_r) + 3'h1) & mask_r))
    else $error("beat did not advance by one");

  a_group_kept: assert property (@(posedge burst_clk_i) // [RL8]
    disable iff (!link_rstn_r)
    ld |-> arr_addr_o[AW-1:WRAP_W] == base_r[AW-1:WRAP_W])
    else $error("burst left its group");

  a_flag_idle_high: assert property (@(posedge burst_clk_i) // [RL9]
    disable iff (!link_rstn_r)
    !ld |=> eob_n_r)
    else $error("end flag low outside a transfer");

  a_special_hold: assert property (@(posedge burst_clk_i) // [RL20]
    disable iff (!link_rstn_r)
    state_r == ST_HOLD && !start && !quit |=> $stable(dq_r) && state_r == ST_HOLD)
    else $error("single read data moved");

  // async mode must never wake the burst engine
  a_async_idle: assert property (@(posedge burst_clk_i) // [RL7]
    disable iff (!link_rstn_r)
    cfg_lk_r.read_mode_select && state_r == ST_IDLE |=> state_r == ST_IDLE)
    else $error("burst started in async mode");

endmodule

// *** test/fbr_host.sv ***
// host controller model: burst clock, select, strobe, gating, address
`timescale 1ns/1ps
module fbr_host (
  output logic               bclk_o,
  output fbr_pkg::fbr_link_t link_o,
  output logic [19:0]        addr_o,
  output logic               sp_rd_o,
  output logic [31:0]        sp_data_o
);
  import fbr_pkg::*;
  initial begin
    bclk_o = 1'b0;
    link_o = 3'b110;
    addr_o = '0;
    sp_rd_o = 1'b0;
    sp_data_o = '0;
  end
  // clock stands still between calls; pins move after the falling edge
  task automatic tick(input int n);
    repeat (n) begin
      #3 bclk_o = 1'b1;
      #3 bclk_o = 1'b0;
    end
  endtask
  // select and strobe low over one capture edge, then lines turn over
  task automatic strobe(input logic [19:0] a, input logic sp, input logic [31:0] d);
    link_o = 3'b000;
    addr_o = a;
    sp_rd_o = sp;
    sp_data_o = d;
    tick(1);
    link_o.address_valid_strobe_n = 1'b1;
    addr_o = ~a;
    sp_rd_o = ~sp;
    sp_data_o = ~d;
  endtask
  task automatic pins(input logic cs_n, input logic oe_n);
    link_o.chip_sel_n = cs_n;
    link_o.out_gate_n = oe_n;
  endtask
endmodule

// *** test/fbr_burst_read_test.sv ***
// self-checking bench of the flash burst read block
`timescale 1ns/1ps
module fbr_burst_read_test;
  import fbr_pkg::*;
  typedef struct packed {
    logic [3:0]  lat;
    logic [2:0]  bl;
    logic        wc;
    logic [19:0] a;
    logic [3:0]  len;
  } fbr_row_t;
  localparam fbr_row_t ROWS [5] = '{
    '{4'h1, 3'h2, 1'b0, 20'h00101, 4'h4},
    '{4'h7, 3'h3, 1'b1, 20'h12345, 4'h8},
    '{4'h0, 3'h1, 1'b0, 20'h00011, 4'h2},
    '{4'h3, 3'h1, 1'b1, 20'h00020, 4'h2},
    '{4'h5, 3'h2, 1'b1, 20'h0ABC6, 4'h4}};
  logic        clock_i, resetn_i, cfg_wr_i, prog_busy_i, pend, bmode;
  logic        bclk, sp_rd, dq_oe, flag_n, flag_oe;
  fbr_cfg_t    cfg_wdata_i, cfg, c;
  fbr_link_t   link;
  logic [19:0] addr, arr_addr;
  logic [31:0] arr_data, sp_data, dq;
  int          err_count, check_count, cycles, i;

  fbr_burst_read #(.AW(20), .DW(32)) i_fbr_burst_read (
    .clock_i(clock_i), .resetn_i(resetn_i), .cfg_wr_i(cfg_wr_i), .cfg_wdata_i(cfg_wdata_i),
    .prog_busy_i(prog_busy_i), .cfg_pending_o(pend), .cfg_o(cfg), .burst_mode_o(bmode),
    .burst_clk_i(bclk), .link_i(link), .addr_i(addr), .special_read_i(sp_rd),
    .special_data_i(sp_data), .arr_addr_o(arr_addr), .arr_data_i(arr_data), .dq_o(dq),
    .dq_oe_o(dq_oe), .end_of_burst_flag_n_o(flag_n), .end_of_burst_flag_oe_o(flag_oe));
  fbr_host i_fbr_host (.bclk_o(bclk), .link_o(link), .addr_o(addr), .sp_rd_o(sp_rd),
    .sp_data_o(sp_data));
  // array answers with its own address in the low bits
  assign arr_data = {12'hA5A, arr_addr};

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 8000) begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic fbr_cfg_t mk(input logic [3:0] lat, input logic [2:0] bl, input logic wc);
    fbr_cfg_t r;
    r = CFG_RST;
    r.read_mode_select = 1'b0;
    r.initial_latency_field = lat;
    r.end_flag_timing_select = wc;
    r.burst_length_field = bl;
    return r;
  endfunction
  // write, then run the burst clock until the crossing settles
  task automatic wcfg(input fbr_cfg_t w);
    int n;
    @(posedge clock_i) cfg_wr_i <= 1'b1;
    cfg_wdata_i <= w;
    @(posedge clock_i) cfg_wr_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    for (n = 0; n < 200 && pend !== 1'b0; n++) i_fbr_host.tick(1);
  endtask
  task automatic reset_dev();
    @(posedge clock_i) resetn_i <= 1'b0;
    #1;
    check({dq_oe, flag_oe, bmode}, 3'h0);
    check(cfg, 16'h9CC4);
    i_fbr_host.pins(1'b1, 1'b0);
    i_fbr_host.tick(3);
    repeat (20) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    i_fbr_host.tick(3);
  endtask
  task automatic burst(input fbr_row_t r, input int n);
    int k;
    int f;
    logic [19:0] m;
    m = 20'(r.len) - 20'h1;
    f = int'(r.len) - 1 - int'(r.wc);
    i_fbr_host.strobe(r.a, 1'b0, 32'h0);
    i_fbr_host.tick(int'(r.lat) + 1);
    check({dq_oe, flag_n}, 2'h1);
    for (k = 0; k < n; k++) begin
      i_fbr_host.tick(1);
      check(dq, {12'hA5A, (r.a & ~m) | ((r.a + 20'(k)) & m)});
      check(dq_oe, 1'b1);
      check({flag_oe, flag_n}, {1'b1, (k % r.len) != f});
    end
  endtask

  initial begin
    resetn_i = 1'b0;
    cfg_wr_i = 1'b0;
    prog_busy_i = 1'b0;
    cfg_wdata_i = '0;
    err_count = 0;
    check_count = 0;
    cycles = 0;
    reset_dev();
    $display("done: reset");
    for (i = 0; i < 5; i++) begin
      wcfg(mk(ROWS[i].lat, ROWS[i].bl, ROWS[i].wc));
      check(bmode, 1'b1);
      burst(ROWS[i], int'(ROWS[i].len) + 2);
      i_fbr_host.pins(1'b1, 1'b0);
      i_fbr_host.tick(1);
      $display("done: row %0d", i);
    end
    // gating mid-burst, then a restart strobe, then deselect
    burst(ROWS[4], 1);
    i_fbr_host.pins(1'b0, 1'b1);
    i_fbr_host.tick(1);
    check({dq_oe, flag_oe}, 2'h0);
    i_fbr_host.pins(1'b0, 1'b0);
    i_fbr_host.tick(1);
    check({flag_n, dq}, {1'b0, 12'hA5A, 20'h0ABC4});
    i_fbr_host.strobe(20'h00003, 1'b0, 32'h0);
    i_fbr_host.tick(7);
    check(dq, {12'hA5A, 20'h00003});
    i_fbr_host.pins(1'b1, 1'b0);
    #1;
    check({dq_oe, flag_oe}, 2'h0);
    i_fbr_host.tick(2);
    check(dq_oe, 1'b0);
    i_fbr_host.strobe(20'h00050, 1'b1, 32'h5EC00DA7);
    i_fbr_host.tick(9);
    check({dq_oe, dq}, {1'b1, 32'h5EC00DA7});
    i_fbr_host.pins(1'b1, 1'b0);
    i_fbr_host.tick(1);
    $display("done: gating, restart, deselect, single read");
    @(posedge clock_i) prog_busy_i <= 1'b1;
    wcfg(mk(4'h2, 3'h1, 1'b0));
    check(cfg, mk(4'h5, 3'h2, 1'b1));
    @(posedge clock_i) prog_busy_i <= 1'b0;
    for (i = 0; i < 8; i++) begin
      c = mk(4'h1, 3'(i), 1'b0);
      c.clock_edge_select = 1'b0;
      wcfg(c);
      check({bmode, cfg.clock_edge_select}, {i >= 1 && i <= 3, 1'b1});
    end
    c = mk(4'h1, 3'h3, 1'b0);
    c.read_mode_select = 1'b1;
    wcfg(c);
    i_fbr_host.strobe(20'h00004, 1'b0, 32'h0);
    i_fbr_host.tick(8);
    check({bmode, dq_oe}, 2'h0);
    i_fbr_host.pins(1'b1, 1'b0);
    $display("done: codes and refusals");
    wcfg(mk(ROWS[2].lat, ROWS[2].bl, ROWS[2].wc));
    burst(ROWS[2], 3);
    reset_dev();
    $display("done: reset mid-burst");
    results();
  end
endmodule
